// ==== hdl/byte_mem.sv ====
// Simple dual-port byte memory with a registered read port.
// Assumes one clock for both ports; contents start at a fixed fill value.
`timescale 1ns/10ps
module byte_mem #(
  parameter int         WIDTH  = 8,
  parameter int         DEPTH  = 1024,
  parameter logic [7:0] FILL   = 8'hff
) (
  input  wire logic                     clk,     // Memory clock.
  input  wire logic                     wr_en,   // Write strobe.
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write address.
  input  wire logic [WIDTH-1:0]         wr_data, // Write data.
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read address.
  output logic      [WIDTH-1:0]         rd_data  // Registered read data.
);
  logic [WIDTH-1:0] cells [DEPTH];

  if (DEPTH < 2 || WIDTH > 8) begin : g_check
    $error("byte_mem: unsupported width or depth");
  end

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      cells[i] = FILL[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= cells[rd_addr];
  end
endmodule

// ==== hdl/eeprom_core.sv ====
// Command layer of a 1,024-byte two-wire serial EEPROM with page buffer and write protect.
// Assumes bus pins arrive asynchronously and are sampled by two flip-flops on core_clk.
// Behaviour
// - Word address is ten bits: two in the device byte, eight in the word byte.
// - Device acknowledges device byte, word byte and each received data byte.
// - Stop after write data starts a programming cycle; bus is ignored meanwhile.
// - One cycle stores up to 16 bytes of one row; fewer is accepted.
// - Page write: up to fifteen further bytes, each acknowledged; cycle starts at Stop.
// - After each written byte only the low four address bits increment.
// - During programming the device byte is not acknowledged; afterwards it is.
// - High write-protect input blocks all writes; low means no protection.
// - Write protect is sampled at the Stop; later changes do not matter.
// - Protected write is still acknowledged, but no cycle starts; ready at once.
// - Address counter holds last accessed address plus one, kept between operations.
// - Read address wraps from the last byte to the first.
// - Read device byte is acknowledged and the byte at the counter shifts out.
// - A no-acknowledge from the master in the ninth clock ends the read.
// - Address bits in a read device byte are ignored.
// - Each master acknowledge increments the address and sends the next byte.
// - Array contents start as all ones.
// - Device byte: type in 7..4, select in 3, address 9..8 in 2..1, direction in 0.
// - Matching type and select is acknowledged; a mismatch returns to standby.
`timescale 1ns/10ps
module eeprom_core
  import eeprom_pkg::*;
#(
  parameter logic [3:0] dev_type_id = 4'h5,       // Arbitrary value, set per product.
  parameter int         prog_cycles = PROG_CYCLES // Programming time in core cycles.
) (
  input  wire logic core_clk,        // Core clock, 250 MHz.
  input  wire logic reset_n,         // Synchronous reset, active low.
  input  wire logic scl,             // Bus clock pin.
  input  wire logic sda_in,          // Bus data pin level.
  output logic      sda_out,         // Bus data drive value, always low.
  output logic      sda_oe,          // Bus data drive enable.
  input  wire logic write_protect,   // Write-protect pin, high protects.
  input  wire logic chip_select_bit  // Hardware select strap pin.
);
  localparam int WAIT_W = $clog2(prog_cycles + 1);

  if (prog_cycles < 32) begin : g_check
    $error("eeprom_core: prog_cycles too small");
  end

  dev_state_t                 state;
  dev_state_t                 next_state;
  logic [3:0]                 pin_raw;
  logic [3:0]                 pin_meta;
  logic [3:0]                 pin_sync;
  logic                       scl_s;
  logic                       sda_s;
  logic                       wp_s;
  logic                       sel_s;
  logic                       scl_q;
  logic                       sda_q;
  logic                       start_seen;
  logic                       stop_seen;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       byte_done;
  logic                       ack_end;
  logic                       busy;
  logic                       rx_state;
  logic                       dev_match;
  logic                       give_ack;
  logic                       begin_prog;
  logic                       load_tx;
  logic [3:0]                 bit_cnt;
  logic [7:0]                 shift;
  logic [7:0]                 tx_byte;
  logic                       mst_ack;
  logic                       drive_low;
  logic [1:0]                 hi_bits;
  logic [WORD_ADDR_W-1:0]     addr_cnt;
  logic [PAGE_BYTES-1:0]      mask;
  logic [4:0]                 copy_idx;
  logic [PAGE_ADDR_W-1:0]     copy_q;
  logic                       copy_v;
  logic [WAIT_W-1:0]          wait_cnt;
  logic [7:0]                 page_rd;
  logic [7:0]                 array_rd;
  logic                       array_we;

  // Two-flop synchronisers for scl, sda, write protect and select strap.
  // The bus lines reset to their idle high level, so no false edge follows reset.
  assign pin_raw = {chip_select_bit, write_protect, sda_in, scl};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        pin_meta[i] <= (i < 2);
        pin_sync[i] <= (i < 2);
      end else begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end
  end

  assign scl_s = pin_sync[0];
  assign sda_s = pin_sync[1];
  assign wp_s  = pin_sync[2];
  assign sel_s = pin_sync[3];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign start_seen = scl_s && scl_q && sda_q && !sda_s;
  assign stop_seen  = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise   = scl_s && !scl_q;
  assign scl_fall   = !scl_s && scl_q;
  assign byte_done  = scl_fall && (bit_cnt == BIT_ACK);
  assign ack_end    = scl_fall && (bit_cnt == BIT_END);
  assign busy       = (state == ST_COPY) || (state == ST_WAIT);
  assign rx_state   = (state == ST_DEV) || (state == ST_WORD) || (state == ST_DATA);
  assign dev_match  = (shift[DEV_TYPE_LSB +: 4] == dev_type_id)
                      && (shift[DEV_SEL_BIT] == sel_s);
  assign give_ack   = byte_done && (((state == ST_DEV) && dev_match)
                      || (state == ST_WORD) || (state == ST_DATA));
  assign begin_prog = !busy && stop_seen && (state == ST_DATA) && (mask != '0)
                      && !wp_s;
  assign load_tx    = ack_end && (((state == ST_DEV) && shift[DEV_RW_BIT])
                      || ((state == ST_READ) && mst_ack));

  always_comb begin
    next_state = state;
    if (state == ST_COPY) begin
      if (copy_idx == COPY_LAST) begin
        next_state = ST_WAIT;
      end
    end else if (state == ST_WAIT) begin
      if (wait_cnt == '0) begin
        next_state = ST_IDLE;
      end
    end else if (start_seen) begin
      next_state = ST_DEV;
    end else if (stop_seen) begin
      next_state = begin_prog ? ST_COPY : ST_IDLE;
    end else if (byte_done && (state == ST_DEV) && !dev_match) begin
      next_state = ST_IDLE;
    end else if (ack_end) begin
      case (state)
        ST_DEV:  next_state = shift[DEV_RW_BIT] ? ST_READ : ST_WORD;
        ST_WORD: next_state = ST_DATA;
        ST_DATA: next_state = ST_DATA;
        ST_READ: next_state = mst_ack ? ST_READ : ST_IDLE;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter: 1..8 after data clocks, 9 after the acknowledge clock.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bit_cnt <= 4'h0;
    end else if (busy || start_seen || ack_end) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && (state != ST_IDLE) && (bit_cnt < BIT_END)) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shift <= 8'h00;
    end else if (!busy && scl_rise && rx_state && (bit_cnt < BIT_ACK)) begin
      shift <= {shift[6:0], sda_s};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mst_ack <= 1'b0;
    end else if (scl_rise && (state == ST_READ) && (bit_cnt == BIT_ACK)) begin
      mst_ack <= !sda_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx_byte <= 8'h00;
    end else if (load_tx) begin
      tx_byte <= array_rd;
    end else if (scl_fall && (state == ST_READ) && (bit_cnt != 4'h0)
                 && (bit_cnt < BIT_ACK)) begin
      tx_byte <= {tx_byte[6:0], 1'b0};
    end
  end

  // Open-drain data drive: low for acknowledges and for zero read bits.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      drive_low <= 1'b0;
    end else if (busy || start_seen || stop_seen) begin
      drive_low <= 1'b0;
    end else if (byte_done) begin
      drive_low <= give_ack;
    end else if (ack_end) begin
      drive_low <= load_tx && !array_rd[7];
    end else if (scl_fall && (state == ST_READ) && (bit_cnt != 4'h0)
                 && (bit_cnt < BIT_ACK)) begin
      drive_low <= !tx_byte[6];
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hi_bits <= 2'b00;
    end else if (byte_done && (state == ST_DEV) && !shift[DEV_RW_BIT]) begin
      hi_bits <= shift[DEV_HI_LSB +: 2];
    end
  end

  // Address counter: last accessed location plus one, kept between operations.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      addr_cnt <= ADDR_RESET;
    end else if (byte_done && (state == ST_WORD)) begin
      addr_cnt <= {hi_bits, shift};
    end else if (byte_done && (state == ST_DATA)) begin
      addr_cnt[PAGE_ADDR_W-1:0] <= addr_cnt[PAGE_ADDR_W-1:0] + 4'h1;
    end else if (load_tx) begin
      addr_cnt <= addr_cnt + 10'h001;
    end
  end

  // Loaded-byte mask of the page buffer.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mask <= '0;
    end else if ((byte_done && (state == ST_DEV)) || (state == ST_WAIT)) begin
      mask <= '0;
    end else if (byte_done && (state == ST_DATA)) begin
      mask[addr_cnt[PAGE_ADDR_W-1:0]] <= 1'b1;
    end
  end

  // Copy of the page buffer into the array, one entry per cycle.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      copy_idx <= 5'h00;
      copy_q   <= '0;
      copy_v   <= 1'b0;
    end else begin
      copy_idx <= (state == ST_COPY) ? copy_idx + 5'h01 : 5'h00;
      copy_q   <= copy_idx[PAGE_ADDR_W-1:0];
      copy_v   <= (state == ST_COPY) && (copy_idx < COPY_LAST);
    end
  end

  assign array_we = copy_v && mask[copy_q];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wait_cnt <= '0;
    end else if (begin_prog) begin
      wait_cnt <= WAIT_W'(prog_cycles - 1);
    end else if (busy && (wait_cnt != '0)) begin
      wait_cnt <= wait_cnt - WAIT_W'(1);
    end
  end

  byte_mem #(
    .WIDTH (BYTE_W),
    .DEPTH (PAGE_BYTES),
    .FILL  (ERASED_BYTE)
  ) u_page (
    .clk     (core_clk),
    .wr_en   (byte_done && (state == ST_DATA)),
    .wr_addr (addr_cnt[PAGE_ADDR_W-1:0]),
    .wr_data (shift),
    .rd_addr (copy_idx[PAGE_ADDR_W-1:0]),
    .rd_data (page_rd)
  );

  byte_mem #(
    .WIDTH (BYTE_W),
    .DEPTH (MEM_DEPTH),
    .FILL  (ERASED_BYTE)
  ) u_array (
    .clk     (core_clk),
    .wr_en   (array_we),
    .wr_addr ({addr_cnt[WORD_ADDR_W-1:PAGE_ADDR_W], copy_q}),
    .wr_data (page_rd),
    .rd_addr (addr_cnt),
    .rd_data (array_rd)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence dev_taken_s;
    byte_done && (state == ST_DEV) && dev_match;
  endsequence

  sequence dev_refused_s;
    byte_done && (state == ST_DEV) && !dev_match;
  endsequence

  sequence prog_entry_s;
    (state != ST_COPY) ##1 (state == ST_COPY);
  endsequence

  busy_quiet_a: assert property (busy |-> !sda_oe)
    else $error("data line driven during programming");
  dev_nack_a: assert property (dev_refused_s |=> state == ST_IDLE && !sda_oe)
    else $error("mismatched device byte not refused");
  dev_ack_a: assert property (dev_taken_s |=> sda_oe)
    else $error("matching device byte not acknowledged");
  word_load_a: assert property (byte_done && state == ST_WORD
                                |=> addr_cnt == {hi_bits, $past(shift)})
    else $error("word address not loaded");
  page_wrap_a: assert property (byte_done && state == ST_DATA
                                |=> addr_cnt[9:4] == $past(addr_cnt[9:4])
                                && addr_cnt[3:0] == 4'($past(addr_cnt[3:0]) + 1))
    else $error("page address step wrong");
  prog_start_a: assert property (stop_seen && state == ST_DATA && mask != '0 && !wp_s
                                 |=> state == ST_COPY)
    else $error("programming did not start at stop");
  protect_skip_a: assert property (stop_seen && state == ST_DATA && wp_s
                                   |=> state == ST_IDLE)
    else $error("protected write started a cycle");
  empty_write_a: assert property (stop_seen && (state == ST_WORD
                                  || (state == ST_DATA && mask == '0)) |=> state == ST_IDLE)
    else $error("write without data started a cycle");
  copy_len_a: assert property (prog_entry_s |-> ##17 state == ST_WAIT)
    else $error("page copy length wrong");
  read_step_a: assert property (ack_end && state == ST_READ && mst_ack
                                |=> addr_cnt == 10'($past(addr_cnt) + 1))
    else $error("read address did not advance");
  read_end_a: assert property (ack_end && state == ST_READ && !mst_ack
                               |=> state == ST_IDLE ##1 !sda_oe)
    else $error("read not ended by no-acknowledge");
endmodule

// ==== hdl/eeprom_pkg.sv ====
// Constants, field positions and state codes of the two-wire serial EEPROM core.
// Assumes a core clock of 250 MHz; the bus pins are sampled in that domain.
package eeprom_pkg;
  localparam int             WORD_ADDR_W  = 10;
  localparam int             BYTE_W       = 8;
  localparam int             PAGE_BYTES   = 16;
  localparam int             PAGE_ADDR_W  = 4;
  localparam int             MEM_DEPTH    = 1024;
  localparam logic [7:0]     ERASED_BYTE  = 8'hff;
  // Field positions in the device address byte.
  localparam int             DEV_RW_BIT   = 0;
  localparam int             DEV_HI_LSB   = 1;
  localparam int             DEV_SEL_BIT  = 3;
  localparam int             DEV_TYPE_LSB = 4;
  // Bit counter values: eight data clocks, then the acknowledge clock.
  localparam logic [3:0]     BIT_ACK      = 4'h8;
  localparam logic [3:0]     BIT_END      = 4'h9;
  localparam logic [4:0]     COPY_LAST    = 5'h10;
  localparam logic [9:0]     ADDR_RESET   = 10'h000;
  // Longest self-timed programming time and its cycle count, rounded down.
  localparam longint         PROG_TIME_NS = 1000000;
  localparam longint         CORE_CLK_NS  = 4;
  localparam int             PROG_CYCLES  = int'(PROG_TIME_NS / CORE_CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_WORD = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_COPY = 3'b101,
    ST_WAIT = 3'b110
  } dev_state_t;
endpackage

// ==== testbench/link_master.sv ====
// Bit-level master of the two-wire link: Start, Stop, byte out and byte in.
// Assumes the bench resolves the open-drain data line and calls these tasks in turn.
`timescale 1ns/10ps
module link_master (
  output logic      scl,      // Link clock, still between frames.
  output logic      sda_drv,  // Data drive, 1 releases to the pull-up.
  input  wire logic sda_line  // Resolved data line.
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Data changes well after the clock falls, so the device hold time is kept.
  task automatic bit_io(input logic b, output logic r);
    #55 sda_drv = b;
    #20 scl = 1'b1;
    #25 r = sda_line;
    #25 scl = 1'b0;
  endtask

  // Also serves as a repeated Start from mid-frame.
  task automatic start();
    #55 sda_drv = 1'b1;
    #20 scl = 1'b1;
    #25 sda_drv = 1'b0;
    #25 scl = 1'b0;
  endtask

  task automatic stop();
    #55 sda_drv = 1'b0;
    #20 scl = 1'b1;
    #25 sda_drv = 1'b1;
    #100;
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench of the EEPROM core against a byte-array model.
// Assumes the link master model drives the bus; the data line is wired-and.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import eeprom_pkg::*;
  localparam logic [3:0] TYPE_ID = 4'h5; // Arbitrary value.
  logic       core_clk;
  logic       reset_n;
  logic       scl;
  logic       sda_drv;
  wire  logic sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic       write_protect;
  logic       chip_select_bit;
  logic [7:0] mem [1024];
  logic [9:0] cnt;
  logic [31:0] seed = 32'h600e;
  int         fail_count;
  int         num_checks;

  // The device pulls the line to its drive value while enabled; otherwise the pull-up wins.
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

  eeprom_core #(.dev_type_id(TYPE_ID), .prog_cycles(1024)) u_eeprom_core (
    .core_clk(core_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
    .chip_select_bit(chip_select_bit));

  link_master u_link_master (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Pins change at a falling edge; the bus then runs off the core edges.
  task automatic pins(input logic wp, input logic cs);
    @(negedge core_clk);
    write_protect <= wp;
    chip_select_bit <= cs;
    #0.5;
  endtask

  task automatic cmd(input logic [9:0] a, input logic rw);
    logic ack;
    u_link_master.put({TYPE_ID, chip_select_bit, a[9:8], rw}, ack);
    `CHK(ack, 1'b1)
  endtask

  task automatic wr(input logic [9:0] a, input int n, input logic wp, input logic wp_after);
    logic       ack;
    logic [7:0] d;
    logic [3:0] lo;
    lo = a[3:0];
    pins(wp, chip_select_bit);
    u_link_master.start();
    cmd(a, 1'b0);
    u_link_master.put(a[7:0], ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      u_link_master.put(d, ack);
      `CHK(ack, 1'b1)
      if (!wp) mem[{a[9:4], lo}] = d;
      lo++;
    end
    u_link_master.stop();
    cnt = {a[9:4], lo};
    pins(wp_after, chip_select_bit);
  endtask

  task automatic poll(output int tries);
    logic ack;
    tries = 0;
    do begin
      tries++;
      if (tries > 40) begin
        fail_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, tries, 40);
        final_report();
      end
      u_link_master.start();
      u_link_master.put({TYPE_ID, chip_select_bit, 3'b000}, ack);
    end while (!ack);
    u_link_master.stop();
  endtask

  task automatic rd(input logic [9:0] a, input int n, input logic dummy);
    logic       ack;
    logic [7:0] d;
    if (dummy) begin
      u_link_master.start();
      cmd(a, 1'b0);
      u_link_master.put(a[7:0], ack);
      `CHK(ack, 1'b1)
      cnt = a;
    end
    u_link_master.start();
    cmd(10'(rnd()), 1'b1);
    for (int i = 0; i < n; i++) begin
      u_link_master.get(i < n - 1, d);
      `CHK(d, mem[cnt])
      cnt = cnt + 10'h001;
    end
    u_link_master.stop();
  endtask

  initial begin
    int         tries;
    int         n;
    logic       ack;
    logic [9:0] a;
    fail_count = 0;
    num_checks = 0;
    cnt = ADDR_RESET;
    reset_n = 1'b0;
    write_protect = 1'b0;
    chip_select_bit = 1'b0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'hff;
    repeat (8) @(negedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(negedge core_clk);
    pins(1'b0, seed[3]);
    rd(10'h3fe, 4, 1'b1);
    rd(10'h000, 1, 1'b0);
    u_link_master.start();
    u_link_master.put({~TYPE_ID, chip_select_bit, 3'b000}, ack);
    `CHK(ack, 1'b0)
    u_link_master.start();
    u_link_master.put({TYPE_ID, ~chip_select_bit, 3'b001}, ack);
    `CHK(ack, 1'b0)
    u_link_master.stop();
    // First pass wraps past the page end back to the row start; later passes stay in the page.
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 10'h12e : 10'(rnd());
      n = (k == 0) ? 5 : 1 + int'(rnd() % (16 - a[3:0]));
      wr(a, n, 1'b0, 1'b0);
      poll(tries);
      `CHK(tries > 1, 1'b1)
      rd({a[9:4], 4'h0}, 16, 1'b1);
    end
    wr(10'h200, 3, 1'b1, 1'b1);
    poll(tries);
    `CHK(tries, 1)
    rd(10'h200, 3, 1'b1);
    wr(10'h240, 2, 1'b0, 1'b1);
    poll(tries);
    `CHK(tries > 1, 1'b1)
    rd(10'h240, 2, 1'b1);
    wr(10'h155, 0, 1'b0, 1'b0);
    pins(1'b0, ~chip_select_bit);
    rd(10'h000, 2, 1'b0);
    final_report();
  end
endmodule
